// ---- rtl/tfe_pkg.sv ----
// Package with constants and carrier types for the tape formatter error detect block.
package tfe_pkg;

    // ==========================================================
    // Error register layout
    localparam int ERR_WIDTH        = 16;
    localparam int BIT_DATA_PARITY  = 5;
    localparam int BIT_UNCORR_VPE   = 6;
    localparam int BIT_PREAMBLE_LRC = 7;
    localparam int BIT_SHORT_GAP    = 8;
    localparam int BIT_COUNT_RES    = 9;
    localparam int BIT_SKEW_MARK    = 10;
    localparam int BIT_CANNOT_EXEC  = 11;
    localparam int BIT_TIMING       = 12;
    localparam int BIT_TIMEOUT      = 13;
    localparam int BIT_UNSAFE       = 14;
    localparam int BIT_CORR_CRC     = 15;
    localparam logic [15:0] ERR_RESET   = 16'h0000;
    // Class B flags: bits 11 to 14 abort a transfer.
    localparam logic [15:0] CLASS_B_MASK = 16'h7800;
    // Status register bit carrying the composite error.
    localparam int STAT_COMPOSITE   = 14;

    // ==========================================================
    // Frame count check: two's complement of a value below 13.
    localparam logic [15:0] FC_MIN_LEN  = 16'h000d;

    // ==========================================================
    // Timing
    localparam longint CLK_HZ         = 20000000;
    localparam longint READ_LIMIT_MS  = 7000;
    localparam longint WRITE_LIMIT_MS = 700;
    localparam longint READ_LIMIT_CYC  = CLK_HZ * READ_LIMIT_MS / 1000;
    localparam longint WRITE_LIMIT_CYC = CLK_HZ * WRITE_LIMIT_MS / 1000;
    localparam int TMR_WIDTH = 28;
    // Clock cycles of end of block that a host gets to drop run through the pin synchroniser.
    localparam int EOB_GRACE = 3;

    // ==========================================================
    // Commands issued by the controller.
    typedef enum logic [2:0] {
        TFE_CMD_NONE    = 3'h0,
        TFE_CMD_READ    = 3'h1,
        TFE_CMD_WRITE   = 3'h3,
        TFE_CMD_SPACE   = 3'h2,
        TFE_CMD_WCHECK  = 3'h6,
        TFE_CMD_REWIND  = 3'h7
    } tfe_cmd_t;

    // Operation tracking states.
    typedef enum logic [1:0] {
        TFE_IDLE = 2'b00,
        TFE_WAIT = 2'b01,
        TFE_XFER = 2'b11,
        TFE_DONE = 2'b10
    } tfe_state_t;

    // Command start strobe with its qualifiers.
    typedef struct packed {
        logic     start;
        tfe_cmd_t cmd;
        logic     reverse;
    } tfe_cmd_req_t;

    // Detector pulses from the read and write data paths.
    typedef struct packed {
        logic dataParityBad;
        logic multiDeadTrack;
        logic deadNoParity;
        logic parityNoDead;
        logic skewOverflow;
        logic singleDeadTrack;
        logic badPreamble;
        logic correctableSkew;
        logic vertParityBad;
        logic lateData;
        logic lrcMismatch;
        logic crcMismatch;
        logic illegalMark;
        logic gapCharSeen;
        logic recordSeen;
        logic charWritten;
        logic writeClkLate;
    } tfe_det_t;

    // Transport and control state sampled at command start.
    typedef struct packed {
        logic        writeLocked;
        logic        tapeStartMarker;
        logic        onLine;
        logic        phaseEncodedStat;
        logic        densitySelect;
        logic        frameCountSet;
        logic        dataBusBusy;
        logic [15:0] frameCount;
    } tfe_ctx_t;

endpackage

// ---- rtl/tfe_error_detect.sv ----
// Error detection and latching for bits 5 to 15 of the formatter error register.
//
// Overview of operation
// [R1] Data bus parity sets bit 5.
// [R2] PE read track faults set bit 6.
// [R3] NRZ vertical parity or late data: bit 6.
// [R4] PE bad preamble or postamble sets bit 7.
// [R5] NRZ write LRC mismatch sets bit 7.
// [R6] Character in early gap sets bit 8.
// [R7] Space ending with nonzero frame count: bit 9.
// [R8] Run held after end of block: bit 9.
// [R9] PE correctable skew warns on bit 10.
// [R10] NRZ illegal tape mark sets bit 10.
// [R11] Write protected or reverse at start: bit 11.
// [R12] Density select versus PE status: bit 11.
// [R13] Space or write without frame count set.
// [R14] Short NRZ frame count sets bit 11.
// [R15] Late write clock sets bit 12.
// [R16] Transfer with data bus busy: bit 12.
// [R17] No record in 7 s: bit 13.
// [R18] No write record in 0.7 s: bit 13.
// [R19] Command on off-line transport sets bit 14.
// [R20] Power low warning sets bit 14.
// [R21] PE single dead track sets bit 15.
// [R22] NRZ CRC mismatch sets bit 15.
// [R23] Class B aborts transfer, class A not.
// [R24] Error during transfer raises exception line.
// [R25] Error while idle raises attention line.
// [R26] Composite status bit follows any error.
// [R27] Flags latch until drive clear or reset.
// [R28] Timeout counters run from command to record.
`timescale 1ns/1ns
`default_nettype none
module tfe_error_detect #(
    parameter longint READ_LIMIT  = tfe_pkg::READ_LIMIT_CYC,  // Read or space timeout cycles.
    parameter longint WRITE_LIMIT = tfe_pkg::WRITE_LIMIT_CYC  // Write timeout cycles.
) (
    input  wire logic                 clk,              // Formatter clock, 20 MHz.
    input  wire logic                 reset,            // Synchronous reset, active high.
    input  wire tfe_pkg::tfe_cmd_req_t cmdReq,          // Command start strobe and code.
    input  wire tfe_pkg::tfe_ctx_t    ctx,              // Transport and control state.
    input  wire tfe_pkg::tfe_det_t    det,              // Data path detector pulses.
    input  wire logic                 driveClear,       // Drive clear command pulse.
    input  wire logic                 endOfBlock,       // End of block asserted by device.
    input  wire logic                 runLine,          // Run signal from controller pin.
    input  wire logic                 powerLowWarn,     // Low line power warning pin.
    input  wire logic                 xferDone,         // Data transfer or space finished.
    input  wire logic [15:0]          errLowBits,       // Bits 0 to 4 from outside logic.
    output logic [15:0]               errorFlags,       // Error register read value.
    output logic                      compositeErr,     // Composite error status bit.
    output logic                      exceptionLine,    // Exception to controller.
    output logic                      attentionLine,    // Attention to controller.
    output logic                      abortXfer,        // Abort request for transfer.
    output logic                      goActive          // Operation in progress.
);
    import tfe_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [1:0] runSync_r;
    logic [1:0] powerSync_r;

    // Two flip-flops on each pin input; only the second stage is read.
    always_ff @(posedge clk) begin
        if (reset) begin
            runSync_r   <= 2'h0;
            powerSync_r <= 2'h0;
        end else begin
            runSync_r   <= {runSync_r[0], runLine};
            powerSync_r <= {powerSync_r[0], powerLowWarn};
        end
    end

    wire logic runS   = runSync_r[1];
    wire logic powerS = powerSync_r[1];

    // Counts clock cycles of end of block so a host that drops run is not blamed for synchroniser delay.
    logic [1:0] eobAge_r;
    always_ff @(posedge clk) begin
        if (reset || !endOfBlock) begin
            eobAge_r <= 2'h0;
        end else if (eobAge_r != 2'(EOB_GRACE)) begin
            eobAge_r <= eobAge_r + 2'h1;
        end
    end

    wire logic runHeld = endOfBlock && runS && (eobAge_r == 2'(EOB_GRACE));       // R8

    // ==========================================================
    // Operation tracking
    tfe_state_t state_r;
    tfe_cmd_t   cmd_r;
    logic       isPe_r;

    // Returns true for commands that move data.
    function automatic logic isXfer(input tfe_cmd_t c);
        return (c == TFE_CMD_READ) || (c == TFE_CMD_WRITE) || (c == TFE_CMD_WCHECK);
    endfunction

    // Returns true for commands that write tape.
    function automatic logic isWrite(input tfe_cmd_t c);
        return c == TFE_CMD_WRITE;
    endfunction

    wire logic readLike = (cmd_r == TFE_CMD_READ) || (cmd_r == TFE_CMD_WCHECK);
    wire logic peRead   = (state_r != TFE_IDLE) && isPe_r && readLike;
    wire logic nrzRead  = (state_r != TFE_IDLE) && !isPe_r && readLike;
    wire logic nrzWrite = (state_r != TFE_IDLE) && !isPe_r && isWrite(cmd_r);
    wire logic nrzOp    = (state_r != TFE_IDLE) && !isPe_r;
    wire logic inXfer   = (state_r != TFE_IDLE) && isXfer(cmd_r);

    // Command start checks against the transport and control state.
    logic execBad;
    logic timingBad;
    logic unsafeCmd;
    always_comb begin
        execBad = 1'b0;
        if (isWrite(cmdReq.cmd) && ctx.writeLocked) execBad = 1'b1;                // R11
        if (cmdReq.reverse && ctx.tapeStartMarker) execBad = 1'b1;                 // R11
        if (ctx.densitySelect != ctx.phaseEncodedStat) execBad = 1'b1;            // R12
        if ((cmdReq.cmd == TFE_CMD_SPACE || isWrite(cmdReq.cmd)) && !ctx.frameCountSet) begin
            execBad = 1'b1;                                                        // R13
        end
        if ((cmdReq.cmd == TFE_CMD_READ || isWrite(cmdReq.cmd)) && !ctx.densitySelect
            && ((16'h0000 - ctx.frameCount) < FC_MIN_LEN)) begin
            execBad = 1'b1;                                                        // R14
        end
        timingBad = isXfer(cmdReq.cmd) && ctx.dataBusBusy;                         // R16
        unsafeCmd = !ctx.onLine;                                                   // R19
    end

    wire logic startOk = cmdReq.start && (cmdReq.cmd != TFE_CMD_NONE);

    // ==========================================================
    // Timeout counter
    logic [TMR_WIDTH-1:0] tmr_r;
    logic                 timeoutHit;

    always_comb begin
        timeoutHit = 1'b0;
        if (state_r == TFE_WAIT) begin
            if (isWrite(cmd_r)) begin
                timeoutHit = tmr_r == TMR_WIDTH'(WRITE_LIMIT - 1);                 // R18
            end else if (cmd_r != TFE_CMD_REWIND) begin
                timeoutHit = tmr_r == TMR_WIDTH'(READ_LIMIT - 1);                  // R17
            end
        end
    end

    // Counts from command start until the first record is seen.
    always_ff @(posedge clk) begin
        if (reset || startOk || state_r != TFE_WAIT) begin
            tmr_r <= '0;                                                           // R28
        end else if (!det.recordSeen && !timeoutHit) begin
            tmr_r <= tmr_r + 1'b1;                                                 // R28
        end
    end

    // ==========================================================
    // Error sources for this cycle
    logic [15:0] errSet;
    logic        classBNow;

    always_comb begin
        errSet = 16'h0000;
        errSet[BIT_DATA_PARITY] = det.dataParityBad;                               // R1
        errSet[BIT_UNCORR_VPE] = (peRead && (det.multiDeadTrack || det.deadNoParity
                                  || det.parityNoDead || det.skewOverflow))        // R2
                              || (nrzRead && (det.vertParityBad || det.lateData)); // R3
        errSet[BIT_PREAMBLE_LRC] = (peRead && det.badPreamble)                     // R4
                                || (nrzWrite && det.lrcMismatch);                  // R5
        errSet[BIT_SHORT_GAP] = det.gapCharSeen;                                   // R6
        errSet[BIT_COUNT_RES] = (cmd_r == TFE_CMD_SPACE && state_r != TFE_IDLE
                                 && xferDone && ctx.frameCount != 16'h0000)        // R7
                             || runHeld;                                           // R8
        errSet[BIT_SKEW_MARK] = (peRead && det.correctableSkew)                    // R9
                             || (nrzRead && det.illegalMark);                      // R10
        errSet[BIT_CANNOT_EXEC] = startOk && execBad;                              // R11
        errSet[BIT_TIMING] = (state_r != TFE_IDLE && isWrite(cmd_r) && det.writeClkLate)
                          || (startOk && timingBad);                               // R15 R16
        errSet[BIT_TIMEOUT] = timeoutHit;                                          // R17 R18
        errSet[BIT_UNSAFE] = (startOk && unsafeCmd) || powerS;                     // R19 R20
        errSet[BIT_CORR_CRC] = (peRead && det.singleDeadTrack)                     // R21
                            || (nrzOp && det.crcMismatch);                         // R22
        classBNow = |(errSet & CLASS_B_MASK);
    end

    // Tracks the operation from start through record wait to completion.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= TFE_IDLE;
            cmd_r   <= TFE_CMD_NONE;
            isPe_r  <= 1'b0;
        end else begin
            case (state_r)
                TFE_IDLE: begin
                    if (startOk && !(execBad || timingBad || unsafeCmd)) begin
                        state_r <= TFE_WAIT;
                        cmd_r   <= cmdReq.cmd;
                        isPe_r  <= ctx.phaseEncodedStat;
                    end
                end
                TFE_WAIT: begin
                    if (classBNow || xferDone) begin
                        state_r <= TFE_DONE;                                       // R23
                    end else if (det.recordSeen) begin
                        state_r <= TFE_XFER;                                       // R28
                    end
                end
                TFE_XFER: begin
                    if (classBNow || xferDone) begin
                        state_r <= TFE_DONE;                                       // R23
                    end
                end
                TFE_DONE: begin
                    state_r <= TFE_IDLE;
                    cmd_r   <= TFE_CMD_NONE;
                end
                default: state_r <= TFE_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Error register and notification lines
    logic [15:0] err_r;
    logic [15:0] err_nxt;

    // New flags are merged in so a set in the clear cycle survives.
    always_comb begin
        err_nxt = driveClear ? (ERR_RESET | errSet) : (err_r | errSet);            // R27
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            err_r <= ERR_RESET;                                                    // R27
        end else begin
            err_r <= err_nxt;                                                      // R27
        end
    end

    wire logic newErr = |errSet;

    // Registered outputs: read value, composite bit, lines and abort.
    always_ff @(posedge clk) begin
        if (reset) begin
            errorFlags    <= ERR_RESET;
            compositeErr  <= 1'b0;
            exceptionLine <= 1'b0;
            attentionLine <= 1'b0;
            abortXfer     <= 1'b0;
            goActive      <= 1'b0;
        end else begin
            errorFlags    <= {err_nxt[15:5], errLowBits[4:0]};
            compositeErr  <= |err_nxt || |errLowBits[4:0];                         // R26
            exceptionLine <= (exceptionLine && !driveClear) || (inXfer && newErr); // R24
            attentionLine <= (attentionLine && !driveClear)
                          || ((state_r == TFE_IDLE || cmd_r == TFE_CMD_REWIND) && newErr); // R25
            abortXfer     <= inXfer && classBNow;                                  // R23
            goActive      <= state_r == TFE_WAIT || state_r == TFE_XFER;
        end
    end

endmodule
`default_nettype wire

// ---- verif/tfe_error_detect_assertions.sv ----
// Concurrent checks on the ports of the error detect block.
`timescale 1ns/1ns
`default_nettype none
module tfe_error_detect_assertions (
    input wire logic                  clk,           // Formatter clock.
    input wire logic                  reset,         // Synchronous reset.
    input wire tfe_pkg::tfe_cmd_req_t cmdReq,        // Command request.
    input wire tfe_pkg::tfe_ctx_t     ctx,           // Transport context.
    input wire tfe_pkg::tfe_det_t     det,           // Detector pulses.
    input wire logic                  driveClear,    // Drive clear pulse.
    input wire logic                  endOfBlock,    // End of block.
    input wire logic                  runLine,       // Run pin.
    input wire logic                  powerLowWarn,  // Power warning pin.
    input wire logic                  xferDone,      // Transfer finished.
    input wire logic [15:0]           errLowBits,    // Low error bits.
    input wire logic [15:0]           errorFlags,    // Error register.
    input wire logic                  compositeErr,  // Composite error.
    input wire logic                  exceptionLine, // Exception line.
    input wire logic                  attentionLine, // Attention line.
    input wire logic                  abortXfer,     // Abort pulse.
    input wire logic                  goActive       // Operation active.
);
    import tfe_pkg::*;
    // ==========================================================
    // Clocking and named steps.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence sClassBSet;
        (errorFlags & CLASS_B_MASK) != 16'h0000;
    endsequence
    sequence sQuiet;
        det == '0 && !cmdReq.start && !endOfBlock && !goActive && !powerLowWarn;
    endsequence
    AST_PARITY: assert property (det.dataParityBad |=> errorFlags[5])
        else $error("parity flag not set");
    AST_POWER: assert property (powerLowWarn |-> ##[2:3] errorFlags[14])
        else $error("power warning flag late");
    AST_COMPOSITE: assert property (errorFlags != 16'h0000 |-> ##[0:1] compositeErr)
        else $error("composite bit missing");
    AST_LATCH: assert property ((|($past(errorFlags[15:5]) & ~errorFlags[15:5])) |-> $past(driveClear))
        else $error("flag dropped without clear");
    AST_ABORT: assert property (abortXfer |-> sClassBSet)
        else $error("abort without class B flag");
    AST_EXC: assert property ($rose(exceptionLine) |-> errorFlags != 16'h0000)
        else $error("exception without error");
    AST_ATTENTION_LINE: assert property ($rose(attentionLine) |-> errorFlags != 16'h0000)
        else $error("attention without error");
    AST_TIMEOUT: assert property ($rose(errorFlags[13]) |-> $past(goActive) && $past(goActive, 8))
        else $error("timeout flag too early");
    AST_CLEAR: assert property (driveClear && !$past(powerLowWarn) && !$past(powerLowWarn, 2) ##0 sQuiet
        |=> errorFlags[15:5] == 11'h000 && !exceptionLine && !attentionLine)
        else $error("clear did not empty register");
endmodule
`default_nettype wire

// ---- verif/tfe_host_model.sv ----
// Host controller model that drives the run pin.
`timescale 1ns/1ns
`default_nettype none
module tfe_host_model (
    input  wire logic clk,        // Controller clock.
    input  wire logic reset,      // Synchronous reset.
    input  wire logic endOfBlock, // End of block from the device.
    input  wire logic holdRun,    // Keeps run up past end of block.
    input  wire logic goActive,   // Device operation in progress.
    output logic      runLine     // Run request to the device.
);
    // ==========================================================
    // Run is raised during operations and dropped at end of block unless holdRun is set.
    always_ff @(posedge clk) begin
        if (reset) begin
            runLine <= 1'b0;
        end else if (endOfBlock && !holdRun) begin
            runLine <= 1'b0;
        end else if (goActive) begin
            runLine <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- verif/tfe_error_detect_test.sv ----
// Self-checking bench for the error detect block.
`timescale 1ns/1ns
`default_nettype none
module tfe_error_detect_test;
    import tfe_pkg::*;
    logic         clk, reset, driveClear, endOfBlock, runLine, powerLowWarn, xferDone, holdRun;
    logic         compositeErr, exceptionLine, attentionLine, abortXfer, goActive;
    logic [15:0]  errorFlags, errLowBits, e;
    tfe_cmd_req_t cmdReq;
    tfe_ctx_t     ctx, good, x;
    tfe_det_t     det, d;
    tfe_cmd_t     c;
    logic         r;
    int           err_count, checks_done, cyc, n;
    localparam int RD_LIM = 20; // Shortened read timeout for simulation.
    localparam int WR_LIM = 10; // Shortened write timeout for simulation.

    tfe_error_detect #(.READ_LIMIT(RD_LIM), .WRITE_LIMIT(WR_LIM)) uut (.clk(clk), .reset(reset),
        .cmdReq(cmdReq), .ctx(ctx), .det(det), .driveClear(driveClear), .endOfBlock(endOfBlock),
        .runLine(runLine), .powerLowWarn(powerLowWarn), .xferDone(xferDone),
        .errLowBits(errLowBits), .errorFlags(errorFlags), .compositeErr(compositeErr),
        .exceptionLine(exceptionLine), .attentionLine(attentionLine), .abortXfer(abortXfer),
        .goActive(goActive));
    tfe_host_model host (.clk(clk), .reset(reset), .endOfBlock(endOfBlock),
        .holdRun(holdRun), .goActive(goActive), .runLine(runLine));

    // ==========================================================
    // Shared tasks.
    task automatic check(input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic look;
        @(posedge clk);
        #1;
    endtask
    task automatic cmd(input tfe_cmd_t cc, input logic rv, input tfe_ctx_t cx);
        @(posedge clk);
        ctx <= cx;
        cmdReq <= '{1'b1, cc, rv};
        @(posedge clk);
        cmdReq.start <= 1'b0;
    endtask
    task automatic pulse(input tfe_det_t dd);
        @(posedge clk);
        det <= dd;
        @(posedge clk);
        det <= '0;
    endtask
    task automatic finish_op;
        @(posedge clk);
        xferDone <= 1'b1;
        @(posedge clk);
        xferDone <= 1'b0;
        look;
    endtask
    task automatic clear;
        @(posedge clk);
        driveClear <= 1'b1;
        @(posedge clk);
        driveClear <= 1'b0;
        look;
        check(16'h0000, errorFlags);
    endtask
    task automatic waitFlag(input int b);
        n = 0;
        while (errorFlags[b] !== 1'b1 && n < 60) begin
            look;
            n++;
        end
    endtask
    task automatic results;
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Clock and hang guard.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            results();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        reset = 1'b1;
        cmdReq = '0;
        det = '0;
        driveClear = 1'b0;
        endOfBlock = 1'b0;
        powerLowWarn = 1'b0;
        xferDone = 1'b0;
        holdRun = 1'b0;
        errLowBits = 16'h0000;
        good = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'hfff0};
        ctx = good;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        look;
        check(16'h0000, errorFlags);
        // Idle parity error latches and raises attention.
        d = '0;
        d.dataParityBad = 1'b1;
        pulse(d);
        repeat (3) look;
        check(16'h0020, errorFlags);
        check(16'h0003, {14'h0, attentionLine, compositeErr});
        clear;
        // Phase-encoded read: class A keeps going, then the read timeout aborts.
        cmd(TFE_CMD_READ, 1'b0, good);
        d = '0;
        d.singleDeadTrack = 1'b1;
        pulse(d);
        look;
        check(16'h8000, errorFlags);
        check(16'h0003, {14'h0, exceptionLine, goActive});
        waitFlag(13);
        check(16'(RD_LIM), 16'(n + 3));
        check(16'h0001, {15'h0, abortXfer});
        repeat (2) look;
        check(16'h0000, {15'h0, goActive});
        clear;
        // Write with no read-after-write record.
        cmd(TFE_CMD_WRITE, 1'b0, good);
        waitFlag(13);
        check(16'(WR_LIM), 16'(n));
        clear;
        // Late write clock ends the write.
        cmd(TFE_CMD_WRITE, 1'b0, good);
        d = '0;
        d.writeClkLate = 1'b1;
        pulse(d);
        repeat (2) look;
        check(16'h1000, errorFlags);
        check(16'h0000, {15'h0, goActive});
        clear;
        // Commands that cannot be executed are refused.
        for (int i = 0; i < 6; i++) begin
            x = good;
            c = TFE_CMD_READ;
            r = 1'b0;
            e = 16'h0800;
            case (i)
                0: begin x.writeLocked = 1'b1; c = TFE_CMD_WRITE; end
                1: begin x.tapeStartMarker = 1'b1; r = 1'b1; end
                2: x.densitySelect = 1'b0;
                3: begin x.frameCountSet = 1'b0; c = TFE_CMD_SPACE; end
                4: begin x = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'hfff4}; end
                default: begin x.onLine = 1'b0; e = 16'h4000; end
            endcase
            cmd(c, r, x);
            repeat (2) look;
            check(e, errorFlags & e);
            check(16'h0000, {15'h0, goActive});
            clear;
        end
        // Space that ends with frames left over.
        cmd(TFE_CMD_SPACE, 1'b0, good);
        d = '0;
        d.recordSeen = 1'b1;
        pulse(d);
        finish_op;
        look;
        check(16'h0200, errorFlags);
        clear;
        // Recording-mode read at the shortest legal count, then run held past end of block.
        x = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'hfff3};
        cmd(TFE_CMD_READ, 1'b0, x);
        pulse(d);
        d = '0;
        d.gapCharSeen = 1'b1;
        d.crcMismatch = 1'b1;
        d.lateData = 1'b1;
        pulse(d);
        look;
        check(16'h8140, errorFlags);
        check(16'h0003, {14'h0, exceptionLine, goActive});
        // A host that drops run in time raises no count residue flag.
        @(posedge clk);
        endOfBlock <= 1'b1;
        repeat (6) look;
        check(16'h0000, {15'h0, errorFlags[9]});
        @(posedge clk);
        holdRun <= 1'b1;
        endOfBlock <= 1'b0;
        repeat (4) look;
        @(posedge clk);
        endOfBlock <= 1'b1;
        waitFlag(9);
        check(16'h0001, {15'h0, errorFlags[9]});
        @(posedge clk);
        holdRun <= 1'b0;
        endOfBlock <= 1'b0;
        finish_op;
        clear;
        // Rewind is not a transfer, so an error raises attention and not exception.
        cmd(TFE_CMD_REWIND, 1'b0, good);
        d = '0;
        d.dataParityBad = 1'b1;
        pulse(d);
        look;
        check(16'h0001, {14'h0, exceptionLine, attentionLine});
        finish_op;
        clear;
        // Power warning pin.
        @(posedge clk);
        powerLowWarn <= 1'b1;
        @(posedge clk);
        powerLowWarn <= 1'b0;
        repeat (4) look;
        check(16'h4000, errorFlags);
        check(16'h0001, {15'h0, attentionLine});
        clear;
        results();
    end
endmodule

bind tfe_error_detect tfe_error_detect_assertions chk (.clk(clk), .reset(reset),
    .cmdReq(cmdReq), .ctx(ctx), .det(det), .driveClear(driveClear), .endOfBlock(endOfBlock),
    .runLine(runLine), .powerLowWarn(powerLowWarn), .xferDone(xferDone),
    .errLowBits(errLowBits), .errorFlags(errorFlags), .compositeErr(compositeErr),
    .exceptionLine(exceptionLine), .attentionLine(attentionLine), .abortXfer(abortXfer),
    .goActive(goActive));
`default_nettype wire
